// ---- rtl/pss_regs.vh ----
// Constants for the status summary registers and their clearing patterns
`ifndef PSS_REGS_VH
`define PSS_REGS_VH

`define PSS_CMD_ALERT_MASK  8'h1b
`define PSS_CMD_SUM_BYTE    8'h78
`define PSS_CMD_SUM_WORD    8'h79
`define PSS_CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS  8'h7a

`define PSS_SUM_BYTE_RST    8'h00
`define PSS_SUM_WORD_RST    16'h0000
`define PSS_OUTPUT_VOLTAGE_SUMMARY_FLAGS_RST  8'h00
`define PSS_MASK_RST        8'h00

`define PSS_CLR_BUSY_BYTE   8'h80
`define PSS_CLR_BUSY_WORD   16'h0080
`define PSS_CLR_BUSY_UNK    16'h0180

`define PSS_BIT_BUSY        7
`define PSS_BIT_OFF         6
`define PSS_BIT_OUT_OVERVOLT 5
`define PSS_BIT_OUT_OVERCUR 4
`define PSS_BIT_IN_UNDERVOLT 3
`define PSS_BIT_TEMP        2
`define PSS_BIT_COMM_MEM_LOGIC 1
`define PSS_BIT_OTHER_ANY   0
`define PSS_BIT_OUTPUT_VOLTAGE_SUMMARY_SUM    15
`define PSS_BIT_OUTPUT_CURRENT_SUMMARY_SUM    14
`define PSS_BIT_INPUT_SUM   13
`define PSS_BIT_VENDOR_SUM  12
`define PSS_BIT_POWER_GOOD  11
`define PSS_BIT_OTHER_CAT   9

`define PSS_OUTPUT_VOLTAGE_SUMMARY_SUPPORTED  8'hfc
`define PSS_OUTPUT_VOLTAGE_SUMMARY_BIT_OV     7

`define PSS_MASK_IDX_BYTE   2'd0
`define PSS_MASK_IDX_WHIGH  2'd1
`define PSS_MASK_IDX_OUTPUT_VOLTAGE_SUMMARY   2'd2
`define PSS_MASK_IDX_NONE   2'd3

`endif

// ---- rtl/pss_output_voltage_summary_flags.v ----
// Latched output-voltage flag register with write-one-to-clear
`include "pss_regs.vh"
module pss_output_voltage_summary_flags (
   // Clock and reset
   input  wire       ref_clk_in,
   input  wire       rstn_in,
   // Fault events, bit 7 down to bit 2
   input  wire [5:0] set_events_in,
   // Clearing
   input  wire       clear_faults_in,
   input  wire       w1c_valid_in,
   input  wire [7:0] w1c_data_in,
   // Flags
   output wire [7:0] flags_out
);
   reg  [7:0] flags_q;
   reg  [7:0] flags_d;
   wire [7:0] set_vec;
   wire [7:0] clr_vec;

   assign set_vec = {set_events_in, 2'b00};
   assign clr_vec = (clear_faults_in ? 8'hff : 8'h00) |
                    (w1c_valid_in ? w1c_data_in : 8'h00);

   // Set wins over a clear in the same cycle so no event is lost
   always @* begin
      flags_d = ((flags_q & ~clr_vec) | set_vec) &
                `PSS_OUTPUT_VOLTAGE_SUMMARY_SUPPORTED;
   end

   always @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         flags_q <= `PSS_OUTPUT_VOLTAGE_SUMMARY_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags_out = flags_q;
endmodule // pss_output_voltage_summary_flags

// ---- rtl/pss_mask_mem.v ----
// Small mask store, one byte per alert-capable status byte
`include "pss_regs.vh"
module pss_mask_mem #(
   parameter DEPTH = 3
) (
   // Clock and reset
   input  wire       ref_clk_in,
   input  wire       rstn_in,
   // Write port
   input  wire       wr_en_in,
   input  wire [1:0] wr_idx_in,
   input  wire [7:0] wr_data_in,
   // Registered read port
   input  wire [1:0] rd_idx_in,
   output reg  [7:0] rd_data_out,
   // All masks at once for the alert gate
   output wire [23:0] masks_out
);
   reg [7:0] mem_q [0:DEPTH-1];
   integer i;

   always @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_q[i] <= `PSS_MASK_RST;
         end
         rd_data_out <= 8'h00;
      end else begin
         if (wr_en_in && ({30'd0, wr_idx_in} < DEPTH)) begin
            mem_q[wr_idx_in] <= wr_data_in;
         end
         if ({30'd0, rd_idx_in} < DEPTH) begin
            rd_data_out <= mem_q[rd_idx_in];
         end else begin
            rd_data_out <= 8'h00;
         end
      end
   end

   assign masks_out = {mem_q[2], mem_q[1], mem_q[0]};
endmodule // pss_mask_mem

// ---- rtl/pss_status_summary.v ----
// Status summary byte and word with busy, unknown and mask handling
`include "pss_regs.vh"
module pss_status_summary (
   // Clock and reset
   input  wire        ref_clk_in,
   input  wire        rstn_in,
   // Command port from the bus protocol engine
   input  wire        cmd_valid_in,
   input  wire        cmd_write_in,
   input  wire        cmd_word_in,
   input  wire [7:0]  cmd_code_in,
   input  wire [15:0] cmd_wdata_in,
   input  wire        clear_faults_in,
   // Read answer
   output wire [15:0] rdata_out,
   output reg         rvalid_out,
   output reg         cmd_unsupported_out,
   // Fault events, one-cycle pulses
   input  wire        busy_event_in,
   input  wire        unknown_event_in,
   input  wire [5:0]  output_voltage_summary_events_in,
   // Detailed category summaries, levels from their own registers
   input  wire        output_overcurrent_flag_in,
   input  wire        output_current_summary_any_in,
   input  wire        input_undervoltage_flag_in,
   input  wire        input_any_in,
   input  wire        temp_any_in,
   input  wire        comm_memory_logic_any_in,
   input  wire        vendor_any_in,
   input  wire        other_cat_any_in,
   // Live conditions
   input  wire        converting_in,
   input  wire        power_good_live_in,
   // Summary results
   output reg  [15:0] summary_word_out,
   output wire [7:0]  output_voltage_summary_flags_out,
   output reg         alert_req_out
);
   // Busy and unknown flags are the only storage of the summary
   reg         busy_q;
   reg         busy_d;
   reg         unknown_q;
   reg         unknown_d;
   reg  [15:0] rdata_q;
   reg         rd_mask_q;
   reg  [15:0] word_c;
   wire [7:0]  mask_rd;
   wire [23:0] masks;
   wire        wr_byte;
   wire        wr_word;
   wire        clr_busy;
   wire        clr_unk;
   wire        output_voltage_summary_w1c;
   wire        mask_wr;
   wire        is_read;
   wire        known_code;
   wire        other_any;

   function [1:0] mask_index;
      input [7:0] code;
      begin
         case (code)
            `PSS_CMD_SUM_BYTE:   mask_index = `PSS_MASK_IDX_BYTE;
            `PSS_CMD_SUM_WORD:   mask_index = `PSS_MASK_IDX_WHIGH;
            `PSS_CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS: mask_index = `PSS_MASK_IDX_OUTPUT_VOLTAGE_SUMMARY;
            default:             mask_index = `PSS_MASK_IDX_NONE;
         endcase
      end
   endfunction

   assign wr_byte = cmd_valid_in & cmd_write_in & ~cmd_word_in;
   assign wr_word = cmd_valid_in & cmd_write_in & cmd_word_in;
   assign is_read = cmd_valid_in & ~cmd_write_in;

   // Only the exact patterns clear; anything else is ignored
   assign clr_busy = (wr_byte && cmd_code_in == `PSS_CMD_SUM_BYTE &&
                      cmd_wdata_in[7:0] == `PSS_CLR_BUSY_BYTE) ||
                     (wr_word && cmd_code_in == `PSS_CMD_SUM_WORD &&
                      (cmd_wdata_in == `PSS_CLR_BUSY_WORD ||
                       cmd_wdata_in == `PSS_CLR_BUSY_UNK)) ||
                     clear_faults_in;
   assign clr_unk  = (wr_word && cmd_code_in == `PSS_CMD_SUM_WORD &&
                      cmd_wdata_in == `PSS_CLR_BUSY_UNK) ||
                     clear_faults_in;

   assign output_voltage_summary_w1c = wr_byte && cmd_code_in == `PSS_CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS;
   assign mask_wr  = wr_word && cmd_code_in == `PSS_CMD_ALERT_MASK;

   assign known_code = (cmd_code_in == `PSS_CMD_SUM_BYTE) ||
                       (cmd_code_in == `PSS_CMD_SUM_WORD) ||
                       (cmd_code_in == `PSS_CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS) ||
                       (cmd_code_in == `PSS_CMD_ALERT_MASK);

   pss_output_voltage_summary_flags u_output_voltage_summary (
      .ref_clk_in      (ref_clk_in),
      .rstn_in         (rstn_in),
      .set_events_in   (output_voltage_summary_events_in),
      .clear_faults_in (clear_faults_in),
      .w1c_valid_in    (output_voltage_summary_w1c),
      .w1c_data_in     (cmd_wdata_in[7:0]),
      .flags_out       (output_voltage_summary_flags_out)
   );

   pss_mask_mem #(
      .DEPTH (3)
   ) u_mask (
      .ref_clk_in  (ref_clk_in),
      .rstn_in     (rstn_in),
      .wr_en_in    (mask_wr),
      .wr_idx_in   (mask_index(cmd_wdata_in[15:8])),
      .wr_data_in  (cmd_wdata_in[7:0]),
      .rd_idx_in   (mask_index(cmd_wdata_in[15:8])),
      .rd_data_out (mask_rd),
      .masks_out   (masks)
   );

   // Set wins over clear in the same cycle
   always @* begin
      busy_d    = (busy_q & ~clr_busy) | busy_event_in;
      unknown_d = (unknown_q & ~clr_unk) | unknown_event_in;
   end

   // Catch-all: output-voltage flags other than overvoltage, unknown, vendor, other category
   assign other_any = (|output_voltage_summary_flags_out[6:2]) | unknown_q |
                      vendor_any_in | other_cat_any_in;

   // Pure function of detailed flags; no summary bit is stored here
   always @* begin
      word_c = `PSS_SUM_WORD_RST;
      word_c[`PSS_BIT_BUSY]      = busy_q;
      word_c[`PSS_BIT_OFF]       = ~converting_in;
      word_c[`PSS_BIT_OUT_OVERVOLT] =
         output_voltage_summary_flags_out[`PSS_OUTPUT_VOLTAGE_SUMMARY_BIT_OV];
      word_c[`PSS_BIT_OUT_OVERCUR] = output_overcurrent_flag_in;
      word_c[`PSS_BIT_IN_UNDERVOLT] = input_undervoltage_flag_in;
      word_c[`PSS_BIT_TEMP]      = temp_any_in;
      word_c[`PSS_BIT_COMM_MEM_LOGIC] = comm_memory_logic_any_in;
      word_c[`PSS_BIT_OTHER_ANY] = other_any;
      word_c[`PSS_BIT_OUTPUT_VOLTAGE_SUMMARY_SUM]  = |output_voltage_summary_flags_out;
      word_c[`PSS_BIT_OUTPUT_CURRENT_SUMMARY_SUM]  = output_current_summary_any_in;
      word_c[`PSS_BIT_INPUT_SUM] = input_any_in;
      word_c[`PSS_BIT_VENDOR_SUM] = vendor_any_in;
      word_c[`PSS_BIT_OTHER_CAT] = other_cat_any_in;
      word_c[`PSS_BIT_POWER_GOOD] = power_good_live_in;
      // Bits 10 and 8 keep their zero default
   end

   always @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         busy_q    <= 1'b0;
         unknown_q <= 1'b0;
      end else begin
         busy_q    <= busy_d;
         unknown_q <= unknown_d;
      end
   end

   // Read answers one cycle after the request
   always @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         rdata_q             <= `PSS_SUM_WORD_RST;
         rd_mask_q           <= 1'b0;
         rvalid_out          <= 1'b0;
         cmd_unsupported_out <= 1'b0;
      end else begin
         rvalid_out          <= is_read;
         rd_mask_q           <= is_read &&
                                cmd_code_in == `PSS_CMD_ALERT_MASK;
         cmd_unsupported_out <= cmd_valid_in & ~known_code;
         if (is_read) begin
            case (cmd_code_in)
               `PSS_CMD_SUM_BYTE:
                  rdata_q <= {8'h00, word_c[7:0]};
               `PSS_CMD_SUM_WORD:
                  rdata_q <= word_c;
               `PSS_CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS:
                  rdata_q <= {8'h00, output_voltage_summary_flags_out};
               default:
                  rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   // Mask reads come straight from the memory's output register
   assign rdata_out = rd_mask_q ? {8'h00, mask_rd} : rdata_q;

   // Live bits are left out of the alert: they are not events
   always @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         summary_word_out <= `PSS_SUM_WORD_RST;
         alert_req_out    <= 1'b0;
      end else begin
         summary_word_out <= word_c;
         alert_req_out    <=
            |({word_c[7], word_c[5:0]} &
              ~{masks[7], masks[5:0]}) |
            |({word_c[15:12], word_c[9]} &
              ~{masks[15:12], masks[9]}) |
            |(output_voltage_summary_flags_out & ~masks[23:16]);
      end
   end
endmodule // pss_status_summary

// ---- bench/pss_status_summary_asserts.sv ----
// Port assertions for the status summary block
module pss_status_summary_asserts (
   input wire        ref_clk_in,
   input wire        rstn_in,
   input wire        cmd_valid_in,
   input wire        cmd_write_in,
   input wire        cmd_word_in,
   input wire [7:0]  cmd_code_in,
   input wire [15:0] cmd_wdata_in,
   input wire        clear_faults_in,
   input wire        busy_event_in,
   input wire [5:0]  output_voltage_summary_events_in,
   input wire        converting_in,
   input wire        power_good_live_in,
   input wire [15:0] rdata_out,
   input wire        rvalid_out,
   input wire        cmd_unsupported_out,
   input wire [15:0] summary_word_out,
   input wire [7:0]  output_voltage_summary_flags_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   wire rd_req = cmd_valid_in && !cmd_write_in;
   wire wr_req = cmd_valid_in && cmd_write_in;
   wire known  = cmd_code_in == 8'h1b || cmd_code_in == 8'h78 ||
                 cmd_code_in == 8'h79 || cmd_code_in == 8'h7a;
   sequence s_word_rd;
      rd_req && cmd_code_in == 8'h79;
   endsequence
   sequence s_clr_busy;
      wr_req && cmd_word_in && cmd_code_in == 8'h79 &&
      cmd_wdata_in == 16'h0080 && !busy_event_in;
   endsequence
   a_word_read: assert property (s_word_rd |=>
      rvalid_out && rdata_out == summary_word_out) else $error("word read");
   a_byte_mirror: assert property (
      rd_req && cmd_code_in == 8'h78 |=>
      rvalid_out && rdata_out[7:0] == summary_word_out[7:0])
      else $error("byte read differs from word low byte");
   a_live_bits: assert property ($past(rstn_in) |->
      summary_word_out[6] == !$past(converting_in) &&
      summary_word_out[11] == $past(power_good_live_in))
      else $error("live bits wrong");
   a_unused_zero: assert property (
      summary_word_out[10] == 1'b0 && summary_word_out[8] == 1'b0)
      else $error("unused word bits set");
   a_output_voltage_summary_sum: assert property ($past(rstn_in) |->
      summary_word_out[5] == $past(output_voltage_summary_flags_out[7]) &&
      summary_word_out[15] == |$past(output_voltage_summary_flags_out))
      else $error("output voltage summary wrong");
   a_busy_set: assert property (busy_event_in |->
      ##2 summary_word_out[7]) else $error("busy not set");
   a_busy_clear: assert property (s_clr_busy |->
      ##2 !summary_word_out[7]) else $error("busy not cleared");
   a_ov_latch: assert property (output_voltage_summary_events_in[5] |=>
      output_voltage_summary_flags_out[7]) else $error("overvoltage not latched");
   a_ov_hold: assert property (
      output_voltage_summary_flags_out[7] && !clear_faults_in &&
      !(wr_req && cmd_code_in == 8'h7a && cmd_wdata_in[7]) |=>
      output_voltage_summary_flags_out[7]) else $error("overvoltage flag lost");
   a_unsup_code: assert property (cmd_valid_in && !known |=>
      cmd_unsupported_out) else $error("unknown code not flagged");
endmodule // pss_status_summary_asserts

bind pss_status_summary pss_status_summary_asserts chk_u (
   .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid_in),
   .cmd_write_in(cmd_write_in), .cmd_word_in(cmd_word_in),
   .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in),
   .clear_faults_in(clear_faults_in), .busy_event_in(busy_event_in),
   .output_voltage_summary_events_in(output_voltage_summary_events_in), .converting_in(converting_in),
   .power_good_live_in(power_good_live_in), .rdata_out(rdata_out),
   .rvalid_out(rvalid_out), .cmd_unsupported_out(cmd_unsupported_out),
   .summary_word_out(summary_word_out), .output_voltage_summary_flags_out(output_voltage_summary_flags_out));

// ---- bench/pss_host_model.sv ----
// Host controller model issuing status commands
module pss_host_model (
   input  wire         ref_clk_in,
   output logic        cmd_valid_out,
   output logic        cmd_write_out,
   output logic        cmd_word_out,
   output logic [7:0]  cmd_code_out,
   output logic [15:0] cmd_wdata_out,
   input  wire  [15:0] rdata_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_valid_out = 0;
      {cmd_write_out, cmd_word_out, cmd_code_out, cmd_wdata_out} = '1;
   end
   // One-cycle request; idle code and data inverted so stale data never matches
   task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
                       input logic [15:0] d, output logic [15:0] q);
      @(negedge ref_clk_in);
      cmd_valid_out = 1;
      {cmd_write_out, cmd_word_out} = {w, wd};
      {cmd_code_out, cmd_wdata_out} = {c, d};
      // Answer stands from the cycle after the request edge
      @(negedge ref_clk_in);
      q = rdata_in;
      cmd_valid_out = 0;
      {cmd_code_out, cmd_wdata_out} = ~{c, d};
   endtask
endmodule // pss_host_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the status summary block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_in = 0;
   logic        rstn_in = 0;
   logic        clear_faults_in = 0;
   logic        busy_event_in = 0;
   logic        unknown_event_in = 0;
   logic [5:0]  output_voltage_summary_events_in = 0;
   logic [9:0]  lv = 0;
   logic        cmd_valid, cmd_write, cmd_word, rvalid, unsup, alert;
   logic [7:0]  cmd_code, vflags;
   logic [15:0] cmd_wdata, rdata, rd, word;
   int          n_fail = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   logic [15:0] el [10] = '{16'h0010, 16'h4000, 16'h0008, 16'h2000, 16'h0004,
                            16'h0002, 16'h1001, 16'h0201, 16'h0800, 16'h0040};
   pss_host_model host_u (.ref_clk_in(ref_clk_in), .cmd_valid_out(cmd_valid),
      .cmd_write_out(cmd_write), .cmd_word_out(cmd_word),
      .cmd_code_out(cmd_code), .cmd_wdata_out(cmd_wdata), .rdata_in(rdata));
   pss_status_summary dut_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
      .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
      .cmd_word_in(cmd_word), .cmd_code_in(cmd_code),
      .cmd_wdata_in(cmd_wdata), .clear_faults_in(clear_faults_in),
      .rdata_out(rdata), .rvalid_out(rvalid), .cmd_unsupported_out(unsup),
      .busy_event_in(busy_event_in), .unknown_event_in(unknown_event_in),
      .output_voltage_summary_events_in(output_voltage_summary_events_in), .output_overcurrent_flag_in(lv[0]),
      .output_current_summary_any_in(lv[1]), .input_undervoltage_flag_in(lv[2]),
      .input_any_in(lv[3]), .temp_any_in(lv[4]),
      .comm_memory_logic_any_in(lv[5]), .vendor_any_in(lv[6]),
      .other_cat_any_in(lv[7]), .power_good_live_in(lv[8]),
      .converting_in(!lv[9]), .summary_word_out(word),
      .output_voltage_summary_flags_out(vflags), .alert_req_out(alert));
   initial forever #2 ref_clk_in = ~ref_clk_in;
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rd_chk(string nm, logic [7:0] c, logic w, logic [15:0] e);
      host_u.xfer(0, w, c, 16'h0000, rd);
      chk(nm, w ? rd : {8'h00, rd[7:0]}, e);
   endtask
   task automatic wr(logic [7:0] c, logic w, logic [15:0] d);
      host_u.xfer(1, w, c, d, rd);
   endtask
   task automatic ev(logic b, logic u, logic [5:0] v, logic c);
      @(negedge ref_clk_in);
      {busy_event_in, unknown_event_in, output_voltage_summary_events_in, clear_faults_in} =
         {b, u, v, c};
      @(negedge ref_clk_in);
      {busy_event_in, unknown_event_in, output_voltage_summary_events_in, clear_faults_in} = 0;
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Whole run is under two hundred cycles; the ceiling leaves wide margin
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge ref_clk_in);
      @(negedge ref_clk_in) rstn_in = 1;
      rd_chk("byte rst", 8'h78, 0, 16'h0000);
      rd_chk("word rst", 8'h79, 1, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         @(negedge ref_clk_in) lv = 10'h1 << i;
         rd_chk("lw", 8'h79, 1, el[i]);
         rd_chk("lb", 8'h78, 0, el[i] & 16'hff);
      end
      @(negedge ref_clk_in) lv = 0;
      $display("test levels done");
      ev(1, 0, 0, 0);
      rd_chk("busy", 8'h78, 0, 16'h0080);
      wr(8'h78, 0, 16'h0040);
      rd_chk("busy kept", 8'h78, 0, 16'h0080);
      wr(8'h78, 0, 16'h0080);
      rd_chk("busy clr", 8'h78, 0, 16'h0000);
      ev(1, 1, 0, 0);
      wr(8'h79, 1, 16'h0080);
      rd_chk("unk kept", 8'h79, 1, 16'h0001);
      wr(8'h79, 1, 16'h0180);
      rd_chk("both clr", 8'h79, 1, 16'h0000);
      $display("test busy done");
      for (int i = 0; i < 6; i++) begin
         ev(0, 0, 6'h1 << i, 0);
         rd_chk("vflag", 8'h7a, 0, 16'h4 << i);
         rd_chk("vsum", 8'h79, 1, i == 5 ? 16'h8020 : 16'h8001);
         wr(8'h7a, 0, 16'h4 << i);
         rd_chk("vclr", 8'h7a, 0, 16'h0000);
      end
      ev(1, 1, 6'h3f, 0);
      ev(0, 0, 0, 1);
      rd_chk("cleared", 8'h79, 1, 16'h0000);
      rd_chk("bad code", 8'h55, 1, 16'h0000);
      $display("test flags done");
      ev(0, 0, 6'h20, 0);
      repeat (3) @(negedge ref_clk_in);
      chk("alert on", {15'h0, alert}, 16'h0001);
      wr(8'h1b, 1, 16'h78ff);
      wr(8'h1b, 1, 16'h79ff);
      wr(8'h1b, 1, 16'h7aff);
      host_u.xfer(0, 1, 8'h1b, 16'h7a00, rd);
      chk("mask", rd, 16'h00ff);
      repeat (3) @(negedge ref_clk_in);
      chk("alert off", {15'h0, alert}, 16'h0000);
      $display("test mask done");
      give_verdict();
   end
endmodule // tb_top
